//--- acb_pkg.sv
/*
  acb_pkg: constants shared by the command bridge and its read stage.
  Assumes a SystemVerilog-2012 tool; no other dependency.
*/
`default_nettype none
package acb_pkg;
    // ----------------------------------------------------------------
    // AXI channel field widths
    // ----------------------------------------------------------------
    localparam int SIZE_BITS = 3;
    localparam int BURST_BITS = 2;
    localparam int LOCK_BITS = 2;
    localparam int CACHE_BITS = 4;
    localparam int PROT_BITS = 3;
    localparam int RESP_BITS = 2;

    // ----------------------------------------------------------------
    // response codes
    // ----------------------------------------------------------------
    localparam logic [RESP_BITS-1:0] RESP_OKAY = 2'h0;
    localparam logic [RESP_BITS-1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // arbitration modes and command states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ARB_ROUND_ROBIN = 2'b00,
        ARB_WRITE_FIRST = 2'b01,
        ARB_READ_FIRST = 2'b10
    } acb_arb_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GRANT = 2'b01,
        ST_HOLD = 2'b10
    } acb_cmd_state_type;

    // ----------------------------------------------------------------
    // register map (byte offsets) and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ERRCNT = 8'h08;
    localparam int ERRCNT_BITS = 16;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic WR_FIRST_RESET = 1'b1;
    localparam logic HREADY_RESET = 1'b1;
endpackage
`default_nettype wire

//--- acb_rd_if.sv
/*
  acb_rd_if: one returned read beat between the bridge and its stage.
  Assumes both ends run on the bridge clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface acb_rd_if #(
    parameter int data_bits = 32,
    parameter int tag_bits = 4
);
    logic valid;
    logic error;
    logic [tag_bits-1:0] id;
    logic [data_bits-1:0] data;
    modport source (output valid, error, id, data);
    modport sink (input valid, error, id, data);
endinterface
`default_nettype wire

//--- acb_rd_pipe.sv
/*
  acb_rd_pipe: optional register stage on returned read beats.
  Assumes beats arrive on the bridge clock and are never stalled.
*/
`timescale 1ns/10ps
`default_nettype none
module acb_rd_pipe #(
    parameter int stage_count = 1,
    parameter int data_bits = 32,
    parameter int tag_bits = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // read beats
    acb_rd_if.sink i_up,
    acb_rd_if.source o_dn
);
    import acb_pkg::*;

    typedef struct packed {
        logic valid;
        logic error;
        logic [tag_bits-1:0] id;
        logic [data_bits-1:0] data;
    } acb_beat_type;

    generate
        if (stage_count == 1)
        begin : g_reg
            acb_beat_type s_r;
            acb_beat_type s_nxt;
            always_comb
            begin
                s_nxt.valid = i_up.valid;
                s_nxt.error = i_up.error;
                s_nxt.id = i_up.id;
                s_nxt.data = i_up.data;
            end
            always_ff @(posedge i_sys_clk or posedge i_rst)
            begin
                if (i_rst)
                    s_r <= '0;
                else
                    s_r <= s_nxt;
            end
            assign o_dn.valid = s_r.valid;
            assign o_dn.error = s_r.error;
            assign o_dn.id = s_r.id;
            assign o_dn.data = s_r.data;
        end
        else
        begin : g_thru
            assign o_dn.valid = i_up.valid;
            assign o_dn.error = i_up.error;
            assign o_dn.id = i_up.id;
            assign o_dn.data = i_up.data;
        end
    endgenerate
endmodule // acb_rd_pipe
`default_nettype wire

//--- acb_bridge.sv
/*
  acb_bridge: five AXI channels in, one native command channel, one
  write-data channel and one read-data channel out, plus a small
  AHB-Lite control window.
  Assumes the AXI master, the controller and the AHB master all run on
  i_sys_clk, and that the master keeps bready and rready high.
*/
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] only incrementing and wrapping bursts are handled; fixed is never issued
// [R2] lock, cache and protection inputs are ignored
// [R3] every write response is OKAY
// [R4] read response is OKAY or data error, never the reserved codes
// [R5] master keeps write-response ready high at all times
// [R6] master keeps read-data ready high at all times
// [R7] parameter picks round robin, write first or read first arbitration
// [R8] extra pipeline stage parameter, default 1, adds exactly one cycle
// [R9] AXI byte address drops log2 of data bytes to give word address
// [R10] tag width defaults to 4; tags pass through and return unchanged
// [R11] burst length field defaults to 8 bits, one under burst count
// [R12] native burst count is one bit wider and holds length plus one
// [R13] size 3, burst 2, lock 2, cache 4, protection 3, response 2 bits
// [R14] AXI and native data widths match; beats pass one to one
// [R15] native command address width equals controller word address width
// [R16] native side has command, write-data and read-data channels
// [R17] single clock and matching reset drive every channel
// [R18] strobes become byte enables; first, last and tag marked per beat
// [R19] controller read error returns data-error code on that beat
// [R20] last read beat flagged from the requested burst length
module acb_bridge #(
    parameter acb_pkg::acb_arb_type channel_arbitration_select = acb_pkg::ARB_ROUND_ROBIN,
    parameter int extra_pipeline_stage = 1,
    parameter int transaction_tag_bits = 4,
    parameter int burst_length_bits = 8,
    parameter int native_address_bits = 24,
    parameter int native_data_bits = 32,
    parameter int rd_queue_depth = 4,
    parameter int native_tag_bits = transaction_tag_bits,
    parameter int native_burst_count_bits = burst_length_bits + 1,
    parameter int axi_addr_bits = native_address_bits + $clog2(native_data_bits / 8)
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // AXI write address
    input wire logic [transaction_tag_bits-1:0] i_awid,
    input wire logic [axi_addr_bits-1:0] i_awaddr,
    input wire logic [burst_length_bits-1:0] i_awlen,
    input wire logic [acb_pkg::SIZE_BITS-1:0] i_awsize, // [R13]
    input wire logic [acb_pkg::BURST_BITS-1:0] i_awburst,
    input wire logic [acb_pkg::LOCK_BITS-1:0] i_awlock,
    input wire logic [acb_pkg::CACHE_BITS-1:0] i_awcache,
    input wire logic [acb_pkg::PROT_BITS-1:0] i_awprot,
    input wire logic i_awvalid,
    output logic o_awready,
    // AXI write data
    input wire logic [transaction_tag_bits-1:0] i_wid,
    input wire logic [native_data_bits-1:0] i_wdata,
    input wire logic [native_data_bits/8-1:0] i_wstrb,
    input wire logic i_wlast,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI write response
    output logic [transaction_tag_bits-1:0] o_bid,
    output logic [acb_pkg::RESP_BITS-1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI read address
    input wire logic [transaction_tag_bits-1:0] i_arid,
    input wire logic [axi_addr_bits-1:0] i_araddr,
    input wire logic [burst_length_bits-1:0] i_arlen,
    input wire logic [acb_pkg::SIZE_BITS-1:0] i_arsize,
    input wire logic [acb_pkg::BURST_BITS-1:0] i_arburst,
    input wire logic [acb_pkg::LOCK_BITS-1:0] i_arlock,
    input wire logic [acb_pkg::CACHE_BITS-1:0] i_arcache,
    input wire logic [acb_pkg::PROT_BITS-1:0] i_arprot,
    input wire logic i_arvalid,
    output logic o_arready,
    // AXI read data
    output logic [transaction_tag_bits-1:0] o_rid,
    output logic [native_data_bits-1:0] o_rdata,
    output logic [acb_pkg::RESP_BITS-1:0] o_rresp,
    output logic o_rlast,
    output logic o_rvalid,
    input wire logic i_rready,
    // native command channel
    output logic o_cmd_valid,
    input wire logic i_cmd_ready,
    output logic o_cmd_write,
    output logic [native_address_bits-1:0] o_cmd_address,
    output logic [native_burst_count_bits-1:0] o_cmd_burstcount,
    output logic [native_tag_bits-1:0] o_cmd_id,
    // native write data channel
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output logic [native_data_bits-1:0] o_wr_data,
    output logic [native_data_bits/8-1:0] o_wr_byte_en,
    output logic o_wr_begin,
    output logic o_wr_last,
    output logic [native_tag_bits-1:0] o_wr_id,
    // native read data channel
    input wire logic i_rd_valid,
    input wire logic [native_data_bits-1:0] i_rd_data,
    input wire logic i_rd_error,
    input wire logic [native_tag_bits-1:0] i_rd_id,
    // AHB-Lite control window
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);
    import acb_pkg::*;

    localparam int BYTE_SHIFT = $clog2(native_data_bits / 8);
    localparam int QA = $clog2(rd_queue_depth);
    localparam int LAT = extra_pipeline_stage + 1;

    typedef logic [QA:0] acb_ptr_type;

    typedef struct packed {
        acb_cmd_state_type st;
        logic last_wr;
        logic awready;
        logic arready;
        logic cmd_valid;
        logic cmd_write;
        logic [native_address_bits-1:0] cmd_addr;
        logic [native_burst_count_bits-1:0] cmd_count;
        logic [native_tag_bits-1:0] cmd_id;
        logic wready;
        logic wr_valid;
        logic [native_data_bits-1:0] wr_data;
        logic [native_data_bits/8-1:0] wr_be;
        logic wr_first;
        logic wr_begin;
        logic wr_last;
        logic [native_tag_bits-1:0] wr_id;
        logic bvalid;
        logic [RESP_BITS-1:0] bresp;
        logic [transaction_tag_bits-1:0] bid;
        logic rvalid;
        logic [native_data_bits-1:0] rdata;
        logic [RESP_BITS-1:0] rresp;
        logic rlast;
        logic [transaction_tag_bits-1:0] rid;
        logic [rd_queue_depth-1:0][burst_length_bits-1:0] q_len;
        acb_ptr_type q_wr;
        acb_ptr_type q_rd;
        logic [burst_length_bits-1:0] beat;
        logic enable;
        logic [ERRCNT_BITS-1:0] err_cnt;
        logic ahb_wr;
        logic [7:0] ahb_addr;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
    } acb_state_type;

    acb_state_type s_r;
    acb_state_type s_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [native_address_bits-1:0] word_addr(
        input logic [axi_addr_bits-1:0] a);
        word_addr = a[axi_addr_bits-1:BYTE_SHIFT]; // [R9] [R15]
    endfunction

    function automatic logic [native_burst_count_bits-1:0] beat_count(
        input logic [burst_length_bits-1:0] len);
        beat_count = native_burst_count_bits'(len) + native_burst_count_bits'(1); // [R11] [R12]
    endfunction

    // ----------------------------------------------------------------
    // read return stage
    // ----------------------------------------------------------------
    acb_rd_if #(.data_bits(native_data_bits), .tag_bits(native_tag_bits)) rd_in_if ();
    acb_rd_if #(.data_bits(native_data_bits), .tag_bits(native_tag_bits)) rd_out_if ();

    assign rd_in_if.valid = i_rd_valid;
    assign rd_in_if.error = i_rd_error;
    assign rd_in_if.id = i_rd_id;
    assign rd_in_if.data = i_rd_data;

    acb_rd_pipe #(
        .stage_count(extra_pipeline_stage),
        .data_bits(native_data_bits),
        .tag_bits(native_tag_bits)
    ) u_rd_pipe (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_up(rd_in_if.sink),
        .o_dn(rd_out_if.source)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic aw_take;
        logic ar_take;
        logic want_wr;
        logic want_rd;
        logic pick_wr;
        logic q_full;
        logic ahb_take;
        pick_wr = 1'b0;
        aw_take = i_awvalid && s_r.awready;
        ar_take = i_arvalid && s_r.arready;
        q_full = (acb_ptr_type'(s_r.q_wr - s_r.q_rd) == acb_ptr_type'(rd_queue_depth));
        // disabled bridge stops granting; a full length queue blocks reads
        want_wr = i_awvalid && s_r.enable;
        want_rd = i_arvalid && s_r.enable && !q_full;
        ahb_take = i_hsel && i_htrans[1] && i_hready;
        s_nxt = s_r;
        s_nxt.awready = 1'b0;
        s_nxt.arready = 1'b0;
        s_nxt.bvalid = 1'b0;
        s_nxt.bresp = RESP_OKAY; // [R3]
        case (channel_arbitration_select)
            ARB_WRITE_FIRST: pick_wr = want_wr; // [R7]
            ARB_READ_FIRST: pick_wr = want_wr && !want_rd; // [R7]
            default: pick_wr = want_wr && (!want_rd || !s_r.last_wr); // [R7]
        endcase

        // command channel: only one ready is raised at a time
        case (s_r.st)
            ST_IDLE:
            begin
                if (want_wr || want_rd)
                begin
                    s_nxt.st = ST_GRANT;
                    s_nxt.awready = pick_wr;
                    s_nxt.arready = !pick_wr;
                end
            end
            ST_GRANT:
            begin
                // lock, cache, prot, size and burst kind play no part;
                // incr and wrap both go out as start word plus count
                if (aw_take || ar_take) // [R1] [R2]
                begin
                    s_nxt.st = ST_HOLD;
                    s_nxt.cmd_valid = 1'b1; // [R16]
                    s_nxt.last_wr = aw_take;
                    s_nxt.cmd_write = aw_take;
                    s_nxt.cmd_addr = aw_take ? word_addr(i_awaddr) : word_addr(i_araddr); // [R9]
                    s_nxt.cmd_count = aw_take ? beat_count(i_awlen) : beat_count(i_arlen); // [R12]
                    s_nxt.cmd_id = aw_take ? i_awid : i_arid; // [R10]
                end
                else
                begin
                    s_nxt.st = ST_IDLE;
                end
                if (ar_take)
                begin
                    s_nxt.q_len[s_r.q_wr[QA-1:0]] = i_arlen; // [R20]
                    s_nxt.q_wr = s_r.q_wr + acb_ptr_type'(1);
                end
            end
            ST_HOLD:
            begin
                if (i_cmd_ready)
                begin
                    s_nxt.cmd_valid = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = ST_IDLE;
                s_nxt.cmd_valid = 1'b0;
            end
        endcase

        // write data: one-beat holding register, so wready is a flop
        if (s_r.wr_valid && i_wr_ready)
        begin
            s_nxt.wr_valid = 1'b0;
            s_nxt.bvalid = s_r.wr_last; // [R3] [R5]
            s_nxt.bid = s_r.wr_id;
        end
        if (i_wvalid && s_r.wready)
        begin
            s_nxt.wr_valid = 1'b1; // [R14]
            s_nxt.wr_data = i_wdata;
            s_nxt.wr_be = i_wstrb; // [R18]
            s_nxt.wr_begin = s_r.wr_first; // [R18]
            s_nxt.wr_first = i_wlast;
            s_nxt.wr_last = i_wlast; // [R18]
            s_nxt.wr_id = i_wid; // [R18]
        end
        s_nxt.wready = !s_nxt.wr_valid;

        // register writes land in the data phase
        s_nxt.ahb_wr = ahb_take && i_hwrite;
        if (ahb_take)
            s_nxt.ahb_addr = i_haddr[7:0];
        if (s_r.ahb_wr)
        begin
            case (s_r.ahb_addr)
                OFS_CTRL: s_nxt.enable = i_hwdata[0];
                OFS_ERRCNT: s_nxt.err_cnt = '0;
                default: ;
            endcase
        end

        // read return; no stall path exists toward the controller
        s_nxt.rvalid = rd_out_if.valid; // [R6] [R8]
        s_nxt.rlast = 1'b0;
        if (rd_out_if.valid)
        begin
            s_nxt.rdata = rd_out_if.data; // [R14]
            s_nxt.rid = rd_out_if.id; // [R10]
            s_nxt.rresp = rd_out_if.error ? RESP_SLVERR : RESP_OKAY; // [R4] [R19]
            if (s_r.beat == s_r.q_len[s_r.q_rd[QA-1:0]])
            begin
                s_nxt.rlast = 1'b1; // [R20]
                s_nxt.beat = '0;
                s_nxt.q_rd = s_r.q_rd + acb_ptr_type'(1);
            end
            else
            begin
                s_nxt.beat = s_r.beat + burst_length_bits'(1);
            end
            // counted after the clear so a same-cycle error survives it
            if (rd_out_if.error && s_nxt.err_cnt != '1)
                s_nxt.err_cnt = s_nxt.err_cnt + ERRCNT_BITS'(1);
        end

        // read data is fixed at the address phase, from post-write values
        s_nxt.hrdata = '0;
        if (ahb_take && !i_hwrite)
        begin
            case (i_haddr[7:0])
                OFS_CTRL: s_nxt.hrdata = {31'h0, s_nxt.enable};
                OFS_STATUS: s_nxt.hrdata = {29'h0, q_full, s_r.wr_valid, s_r.cmd_valid};
                OFS_ERRCNT: s_nxt.hrdata = 32'(s_nxt.err_cnt);
                default: s_nxt.hrdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) // [R17]
    begin
        if (i_rst)
        begin
            s_r <= '0;
            s_r.enable <= CTRL_ENABLE_RESET;
            s_r.wr_first <= WR_FIRST_RESET;
            s_r.hready <= HREADY_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_awready = s_r.awready;
    assign o_arready = s_r.arready;
    assign o_wready = s_r.wready;
    assign o_bid = s_r.bid;
    assign o_bresp = s_r.bresp;
    assign o_bvalid = s_r.bvalid;
    assign o_rid = s_r.rid;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;
    assign o_rlast = s_r.rlast;
    assign o_rvalid = s_r.rvalid;
    assign o_cmd_valid = s_r.cmd_valid;
    assign o_cmd_write = s_r.cmd_write;
    assign o_cmd_address = s_r.cmd_addr;
    assign o_cmd_burstcount = s_r.cmd_count;
    assign o_cmd_id = s_r.cmd_id;
    assign o_wr_valid = s_r.wr_valid;
    assign o_wr_data = s_r.wr_data;
    assign o_wr_byte_en = s_r.wr_be;
    assign o_wr_begin = s_r.wr_begin;
    assign o_wr_last = s_r.wr_last;
    assign o_wr_id = s_r.wr_id;
    assign o_hreadyout = s_r.hready;
    assign o_hresp = s_r.hresp;
    assign o_hrdata = s_r.hrdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_ONE_GRANT: // [R7]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            !(o_awready && o_arready))
        else $error("both address channels granted at once");
    AST_WR_CMD: // [R9]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (i_awvalid && o_awready) |=> o_cmd_valid && o_cmd_write
            && o_cmd_address == word_addr($past(i_awaddr)))
        else $error("write command address wrong");
    AST_RD_CMD: // [R12]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (i_arvalid && o_arready) |=> o_cmd_valid && !o_cmd_write
            && o_cmd_burstcount == beat_count($past(i_arlen))
            && o_cmd_id == $past(i_arid))
        else $error("read command count or tag wrong");
    AST_CMD_HOLD: // [R16]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (o_cmd_valid && !i_cmd_ready) |=> o_cmd_valid
            && $stable(o_cmd_address) && $stable(o_cmd_id))
        else $error("command changed while stalled");
    AST_BRESP: // [R3]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (o_wr_valid && i_wr_ready && o_wr_last) |=> o_bvalid
            && o_bresp == RESP_OKAY && o_bid == $past(o_wr_id))
        else $error("write response missing or not okay");
    AST_WR_FWD: // [R18]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (i_wvalid && o_wready) |=> o_wr_valid
            && o_wr_byte_en == $past(i_wstrb) && o_wr_id == $past(i_wid))
        else $error("write beat not forwarded");
    AST_RD_LAT: // [R8]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            i_rd_valid |-> ##LAT (o_rvalid && o_rdata == $past(i_rd_data, LAT)))
        else $error("read beat latency wrong");
    AST_RD_ERR: // [R19]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            (i_rd_valid && i_rd_error) |-> ##LAT o_rresp == RESP_SLVERR)
        else $error("read error not reported");
    AST_RRESP_CODE: // [R4]
        assert property (@(posedge i_sys_clk) disable iff (i_rst)
            o_rvalid |-> (o_rresp == RESP_OKAY || o_rresp == RESP_SLVERR))
        else $error("reserved read response code");
endmodule // acb_bridge
`default_nettype wire

//--- acb_ctl_model.sv
/* acb_ctl_model: controller stand-in, takes commands, returns read beats.
   Assumes one clock and in-order read return. */
`timescale 1ns/10ps
`default_nettype none
module acb_ctl_model (
    // native side: clock, command in, handshakes and beats out
    input wire logic i_clk,
    input wire logic [14:0] i_cmd,
    output logic [39:0] o_ctl = 0
);
    logic [12:0] q[$];
    logic go;
    always @(posedge i_clk)
    begin
        if (i_cmd[14] && o_ctl[39] && !i_cmd[13])
            q.push_back(i_cmd[12:0]);
        go = q.size() > 0 && $urandom % 2;
        o_ctl[39:37] <= {2'($urandom), go};
        if (go)
        begin
            o_ctl[36:0] <= {1'($urandom), q[0][3:0], $urandom};
            q[0][12:4] = q[0][12:4] - 9'h1;
            if (q[0][12:4] == 0)
                void'(q.pop_front());
        end
        else
            o_ctl[31:0] <= ~o_ctl[31:0]; // no parked data
    end
endmodule // acb_ctl_model
`default_nettype wire

//--- test_axi_to_stream_command_bridge.sv
/* test_axi_to_stream_command_bridge: random bursts, control window.
   Assumes acb_bridge defaults and acb_ctl_model as controller. */
`timescale 1ns/10ps
`default_nettype none
module test_axi_to_stream_command_bridge;
    import acb_pkg::*;
    logic i_sys_clk = 0, i_rst = 1, i_bready = 1, i_rready = 1;
    logic i_awvalid = 0, i_arvalid = 0, i_wvalid = 0, i_wlast = 0, i_hsel = 1, i_hwrite = 0;
    logic [1:0] i_awburst = 0, i_arburst = 0, i_awlock = 0, i_arlock = 0, i_htrans = 0;
    logic [2:0] i_awsize = 0, i_arsize = 0, i_awprot = 0, i_arprot = 0, i_hsize = 2;
    logic [3:0] i_awid = 0, i_wid = 0, i_arid = 0, i_wstrb = 0, i_awcache = 0, i_arcache = 0;
    logic [7:0] i_awlen = 0, i_arlen = 0, lens[$];
    logic [25:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, i_haddr = 0, i_hwdata = 0, d, o_rdata, o_wr_data, o_hrdata;
    logic o_awready, o_arready, o_wready, o_bvalid, o_rlast, o_rvalid, o_cmd_valid, o_hresp;
    logic o_wr_valid, o_wr_begin, o_wr_last, o_hreadyout, o_cmd_write, i_cmd_ready;
    logic i_wr_ready, i_rd_valid, i_rd_error;
    logic [1:0] o_bresp, o_rresp;
    logic [3:0] o_bid, o_rid, o_cmd_id, o_wr_id, i_rd_id, o_wr_byte_en;
    logic [8:0] o_cmd_burstcount;
    logic [23:0] o_cmd_address;
    logic [31:0] i_rd_data;
    logic [37:0] p1 = 0, p2 = 0;
    int n_errors = 0, checks = 0, nb = 0, cyc = 0, ne = 0;
    wire i_hready = o_hreadyout;
    acb_bridge i_acb_bridge (.*);
    acb_ctl_model i_acb_ctl_model (.i_clk(i_sys_clk),
        .i_cmd({o_cmd_valid, o_cmd_write, o_cmd_burstcount, o_cmd_id}),
        .o_ctl({i_cmd_ready, i_wr_ready, i_rd_valid, i_rd_error, i_rd_id, i_rd_data}));
    always #2.5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        i_htrans <= 2'h2;
        {i_haddr, i_hwrite} <= {24'h0, a, w};
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        {i_htrans, i_hwdata} <= {2'h0, wd};
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        d = o_hrdata;
        chk("hresp", o_hresp, 0);
    endtask
    task automatic burst(input logic w);
        logic [7:0] len = 8'($urandom % 4);
        logic [3:0] id = 4'($urandom);
        logic [25:0] a = 26'($urandom);
        {i_awvalid, i_arvalid, i_awid, i_arid, i_awlen, i_arlen} <= {w, !w, id, id, len, len};
        {i_awaddr, i_araddr, i_awburst, i_arburst} <= {a, a, {2{2'h1 + 2'($urandom % 2)}}};
        {i_awlock, i_arlock, i_awcache, i_arcache, i_awprot, i_arprot} <= 18'($urandom);
        {i_awsize, i_arsize} <= 6'($urandom);
        do @(posedge i_sys_clk); while ((w ? o_awready : o_arready) !== 1'b1);
        {i_awvalid, i_arvalid} <= 2'h0;
        if (!w)
            lens.push_back(len);
        do @(posedge i_sys_clk); while ((o_cmd_valid & i_cmd_ready) !== 1'b1);
        chk("cmd", {o_cmd_write, o_cmd_id, o_cmd_burstcount, o_cmd_address},
            {w, id, 9'(len) + 9'h1, a[25:2]});
        for (int k = 0; w && k <= len; k++)
        begin
            {i_wvalid, i_wid, i_wlast} <= {1'b1, id, k == len};
            {i_wdata, i_wstrb} <= {$urandom, 4'($urandom)};
            do @(posedge i_sys_clk); while (o_wready !== 1'b1);
            i_wvalid <= 0;
            do @(posedge i_sys_clk); while ((o_wr_valid & i_wr_ready) !== 1'b1);
            chk("wr_beat", {o_wr_begin, o_wr_last, o_wr_id, o_wr_byte_en, o_wr_data},
                {k == 0, k == len, id, i_wstrb, i_wdata});
        end
        @(posedge i_sys_clk);
        chk("wr_resp", {o_bvalid, o_bresp, w ? o_bid : id}, {w, RESP_OKAY, id});
    endtask
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (!i_rst)
            chk("rvalid", o_rvalid, p2[37]);
        if (p2[37])
            chk("rbeat", {o_rid, o_rdata, o_rresp, o_rlast},
                {p2[35:0], p2[36] ? RESP_SLVERR : RESP_OKAY, nb == lens[0]});
        if (p2[37])
            nb = (nb == lens[0]) ? 0 : nb + 1;
        if (p2[37] && nb == 0)
            void'(lens.pop_front());
        if (p2[37] && p2[36])
            ne++;
        p2 = p1;
        p1 = {i_rd_valid, i_rd_error, i_rd_id, i_rd_data};
        chk("time", cyc < 5000, 1);
        if (cyc >= 5000)
            results;
    end
    initial
    begin
        void'($urandom(32'h446C));
        repeat (12) @(posedge i_sys_clk);
        i_rst <= 0;
        ahb(0, OFS_CTRL, 0);
        chk("ctrl_rst", d, CTRL_ENABLE_RESET);
        ahb(1, OFS_CTRL, 0);
        ahb(0, OFS_CTRL, 0);
        chk("ctrl", d, 0);
        ahb(0, 8'h0C, 0);
        chk("unmapped", d, 0);
        ahb(1, OFS_CTRL, 1);
        repeat (40)
            burst(1'($urandom));
        repeat (200) @(posedge i_sys_clk);
        ahb(0, OFS_ERRCNT, 0);
        chk("errcnt", d, ne);
        ahb(1, OFS_ERRCNT, 0);
        ahb(0, OFS_STATUS, 0);
        chk("status", d, 0);
        ahb(0, OFS_ERRCNT, 0);
        chk("errclr", d, 0);
        results;
    end
endmodule // test_axi_to_stream_command_bridge
`default_nettype wire
